/* File: design/bal_defs.vh */
/*
 Constants for the byte ALU block: register byte offsets, command codes,
 status flag positions and reset values.
 Assumes inclusion by bare name from the design files; definitions only.
*/
`ifndef BAL_DEFS_VH
`define BAL_DEFS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define BAL_OFS_CMD    8'h00
`define BAL_OFS_ADDR   8'h04
`define BAL_OFS_BANK   8'h08
`define BAL_OFS_ACC    8'h0C
`define BAL_OFS_STATUS 8'h10
`define BAL_OFS_IMM    8'h14
`define BAL_OFS_MDATA  8'h18

// ----------------------------------------------------------------------
// Command codes, CMD[3:0]; bit index in CMD[6:4]
// ----------------------------------------------------------------------
`define BAL_OP_NOP          4'h0
`define BAL_OP_XOR_ACC      4'h1
`define BAL_OP_XOR_MEM      4'h2
`define BAL_OP_XOR_IMM      4'h3
`define BAL_OP_ADC_ACC      4'h4
`define BAL_OP_ADC_MEM      4'h5
`define BAL_OP_ADD_ACC      4'h6
`define BAL_OP_ADD_MEM      4'h7
`define BAL_OP_AND_ACC      4'h8
`define BAL_OP_AND_MEM      4'h9
`define BAL_OP_CLR_BYTE     4'hA
`define BAL_OP_CLR_BIT      4'hB
`define BAL_CMD_BIT_LSB     4
`define BAL_CMD_BIT_MSB     6

// ----------------------------------------------------------------------
// Status flag positions
// ----------------------------------------------------------------------
`define BAL_FLG_CARRY       0
`define BAL_FLG_NIBBLE      1
`define BAL_FLG_ZERO        2
`define BAL_FLG_EXCESS      3
`define BAL_FLG_SCMP        4
`define BAL_FLG_W           5

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define BAL_RST_BYTE        8'h00
`define BAL_RST_FLAGS       5'h00
`define BAL_RST_WORD        32'h0000_0000

`endif

/* File: design/bal_core.v */
/*
 Byte ALU datapath with its own data memory, reached over AHB-Lite.
 Software loads operands, then writes CMD; the command executes in the
 write data phase and updates accumulator, memory byte and flags.
 Assumes one clock, synchronous active-high reset, single word transfers.
*/
// Summary of operation
// - XOR accumulator with memory byte into accumulator; only zero flag changes.
// - XOR accumulator with memory byte, result back to that byte; zero only.
// - XOR accumulator with immediate byte into accumulator; zero flag only.
// - Extended forms address any memory byte directly, ignoring bank select.
// - Add with carry: acc+byte+carry to acc or byte; five arithmetic flags.
// - Add without carry: acc+byte to acc or byte; same five flags.
// - Extended AND into accumulator; zero flag only.
// - Extended AND back into memory byte; zero flag only.
// - Extended clear writes zero byte, flags untouched.
// - Extended bit clear zeroes one selected bit, others and flags kept.
`timescale 1ns/1ps
`include "bal_defs.vh"

module bal_core #(
   parameter MEM_AW = 8
)(
   // Clock and reset
   input wire mclk_in,
   input wire sys_rst_in,
   // AHB-Lite slave
   input wire hsel_in,
   input wire [31:0] haddr_in,
   input wire [1:0] htrans_in,
   input wire hwrite_in,
   input wire [2:0] hsize_in,
   input wire [31:0] hwdata_in,
   input wire hready_in,
   output reg [31:0] hrdata_out,
   output reg hreadyout_out,
   output reg hresp_out,
   // Datapath state
   output reg [7:0] acc_out,
   output reg [4:0] flags_out
);

   localparam DEPTH = 1 << MEM_AW;
   localparam BANK_W = MEM_AW - 7;

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   // Zero test shared by every flag-updating operation
   function is_zero;
      input [7:0] v;
      begin
         is_zero = (v == 8'h00);
      end
   endfunction

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   reg [7:0] mem_r [0:DEPTH-1];
   reg [7:0] acc_r;
   reg [4:0] flags_r;
   reg [7:0] imm_r;
   reg [6:0] cmd_r;
   reg [MEM_AW-1:0] maddr_r;
   reg [BANK_W-1:0] bank_r;
   reg wr_pend_r;
   reg rd_pend_r;
   reg [7:0] baddr_r;

   reg [7:0] acc_nxt;
   reg [4:0] flags_nxt;
   reg [7:0] imm_nxt;
   reg [6:0] cmd_nxt;
   reg [MEM_AW-1:0] maddr_nxt;
   reg [BANK_W-1:0] bank_nxt;
   reg mem_we_nxt;
   reg [MEM_AW-1:0] mem_wa_nxt;
   reg [7:0] mem_wd_nxt;
   reg [31:0] rd_nxt;

   wire addr_take = hsel_in & htrans_in[1] & hready_in;

   // ----------------------------------------------------------------------
   // Operand fetch
   // ----------------------------------------------------------------------
   // Ordinary forms combine the bank with a 7-bit offset
   wire [MEM_AW-1:0] ord_addr = {bank_r, maddr_r[6:0]};
   // Extended forms use the full address, bank ignored
   wire [MEM_AW-1:0] ext_addr = maddr_r;
   wire [3:0] op = hwdata_in[3:0];
   wire [2:0] bit_sel = hwdata_in[`BAL_CMD_BIT_MSB:`BAL_CMD_BIT_LSB];
   wire op_ext = (op >= `BAL_OP_ADC_ACC);
   wire [MEM_AW-1:0] op_addr = op_ext ? ext_addr : ord_addr;
   wire [7:0] mbyte = mem_r[op_addr];

   // ----------------------------------------------------------------------
   // Adder and its flags
   // ----------------------------------------------------------------------
   // Carry-in only for the with-carry forms
   wire use_cin = (op == `BAL_OP_ADC_ACC) | (op == `BAL_OP_ADC_MEM);
   wire cin = use_cin & flags_r[`BAL_FLG_CARRY];
   wire [8:0] sum9 = {1'b0, acc_r} + {1'b0, mbyte} + {8'h00, cin};
   wire [4:0] lo5 = {1'b0, acc_r[3:0]} + {1'b0, mbyte[3:0]} + {4'h0, cin};
   // Signed overflow: like-signed operands giving an unlike-signed sum
   wire add_exc = (acc_r[7] == mbyte[7]) & (sum9[7] != acc_r[7]);
   wire [4:0] add_flags;
   assign add_flags[`BAL_FLG_CARRY] = sum9[8];
   assign add_flags[`BAL_FLG_NIBBLE] = lo5[4];
   assign add_flags[`BAL_FLG_ZERO] = is_zero(sum9[7:0]);
   assign add_flags[`BAL_FLG_EXCESS] = add_exc;
   assign add_flags[`BAL_FLG_SCMP] = add_exc ^ sum9[7];

   wire [7:0] xor_m = acc_r ^ mbyte;
   wire [7:0] xor_i = acc_r ^ imm_r;
   wire [7:0] and_m = acc_r & mbyte;

   // ----------------------------------------------------------------------
   // Next-state: software writes and command execution
   // ----------------------------------------------------------------------
   // Commands run in the write data phase; a NOP only records itself
   always @*
   begin
      acc_nxt = acc_r;
      flags_nxt = flags_r;
      imm_nxt = imm_r;
      cmd_nxt = cmd_r;
      maddr_nxt = maddr_r;
      bank_nxt = bank_r;
      mem_we_nxt = 1'b0;
      mem_wa_nxt = op_addr;
      mem_wd_nxt = 8'h00;
      if (wr_pend_r)
      begin
         if (baddr_r == `BAL_OFS_CMD)
         begin
            cmd_nxt = hwdata_in[6:0];
            case (op)
               `BAL_OP_XOR_ACC:
               begin
                  acc_nxt = xor_m;
                  flags_nxt[`BAL_FLG_ZERO] = is_zero(xor_m);
               end
               `BAL_OP_XOR_MEM:
               begin
                  mem_we_nxt = 1'b1;
                  mem_wd_nxt = xor_m;
                  flags_nxt[`BAL_FLG_ZERO] = is_zero(xor_m);
               end
               `BAL_OP_XOR_IMM:
               begin
                  acc_nxt = xor_i;
                  flags_nxt[`BAL_FLG_ZERO] = is_zero(xor_i);
               end
               `BAL_OP_ADC_ACC, `BAL_OP_ADD_ACC:
               begin
                  acc_nxt = sum9[7:0];
                  flags_nxt = add_flags;
               end
               `BAL_OP_ADC_MEM, `BAL_OP_ADD_MEM:
               begin
                  mem_we_nxt = 1'b1;
                  mem_wd_nxt = sum9[7:0];
                  flags_nxt = add_flags;
               end
               `BAL_OP_AND_ACC:
               begin
                  acc_nxt = and_m;
                  flags_nxt[`BAL_FLG_ZERO] = is_zero(and_m);
               end
               `BAL_OP_AND_MEM:
               begin
                  mem_we_nxt = 1'b1;
                  mem_wd_nxt = and_m;
                  flags_nxt[`BAL_FLG_ZERO] = is_zero(and_m);
               end
               `BAL_OP_CLR_BYTE:
               begin
                  mem_we_nxt = 1'b1;
                  mem_wd_nxt = 8'h00;
               end
               `BAL_OP_CLR_BIT:
               begin
                  mem_we_nxt = 1'b1;
                  mem_wd_nxt = mbyte & ~(8'h01 << bit_sel);
               end
               default:
               begin
                  mem_we_nxt = 1'b0;
               end
            endcase
         end
         else if (baddr_r == `BAL_OFS_ADDR)
            maddr_nxt = hwdata_in[MEM_AW-1:0];
         else if (baddr_r == `BAL_OFS_BANK)
            bank_nxt = hwdata_in[BANK_W-1:0];
         else if (baddr_r == `BAL_OFS_ACC)
            acc_nxt = hwdata_in[7:0];
         else if (baddr_r == `BAL_OFS_STATUS)
            flags_nxt = hwdata_in[`BAL_FLG_W-1:0];
         else if (baddr_r == `BAL_OFS_IMM)
            imm_nxt = hwdata_in[7:0];
         else if (baddr_r == `BAL_OFS_MDATA)
         begin
            // Direct software load of the byte at the full address
            mem_we_nxt = 1'b1;
            mem_wa_nxt = ext_addr;
            mem_wd_nxt = hwdata_in[7:0];
         end
      end
   end

   // ----------------------------------------------------------------------
   // Read data mux
   // ----------------------------------------------------------------------
   // Unmapped offsets read zero with an OKAY answer
   always @*
   begin
      rd_nxt = `BAL_RST_WORD;
      if (baddr_r == `BAL_OFS_CMD)
         rd_nxt = {25'h0, cmd_r};
      else if (baddr_r == `BAL_OFS_ADDR)
         rd_nxt[MEM_AW-1:0] = maddr_r;
      else if (baddr_r == `BAL_OFS_BANK)
         rd_nxt[BANK_W-1:0] = bank_r;
      else if (baddr_r == `BAL_OFS_ACC)
         rd_nxt = {24'h000000, acc_r};
      else if (baddr_r == `BAL_OFS_STATUS)
         rd_nxt = {27'h0, flags_r};
      else if (baddr_r == `BAL_OFS_IMM)
         rd_nxt = {24'h000000, imm_r};
      else if (baddr_r == `BAL_OFS_MDATA)
         rd_nxt = {24'h000000, mem_r[ext_addr]};
   end

   // ----------------------------------------------------------------------
   // Bus phase tracking and registers
   // ----------------------------------------------------------------------
   // Reads take one wait state so that data reflects any write just done
   always @(posedge mclk_in)
   begin
      if (sys_rst_in)
      begin
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         baddr_r <= `BAL_RST_BYTE;
         hrdata_out <= `BAL_RST_WORD;
         hreadyout_out <= 1'b1;
         hresp_out <= 1'b0;
         acc_r <= `BAL_RST_BYTE;
         flags_r <= `BAL_RST_FLAGS;
         imm_r <= `BAL_RST_BYTE;
         cmd_r <= 7'h00;
         maddr_r <= {MEM_AW{1'b0}};
         bank_r <= {BANK_W{1'b0}};
         acc_out <= `BAL_RST_BYTE;
         flags_out <= `BAL_RST_FLAGS;
      end
      else
      begin
         hresp_out <= 1'b0;
         wr_pend_r <= addr_take & hwrite_in;
         if (addr_take)
            baddr_r <= {haddr_in[7:2], 2'b00};
         if (addr_take & ~hwrite_in)
         begin
            rd_pend_r <= 1'b1;
            hreadyout_out <= 1'b0;
         end
         else if (rd_pend_r)
         begin
            rd_pend_r <= 1'b0;
            hrdata_out <= rd_nxt;
            hreadyout_out <= 1'b1;
         end
         acc_r <= acc_nxt;
         flags_r <= flags_nxt;
         imm_r <= imm_nxt;
         cmd_r <= cmd_nxt;
         maddr_r <= maddr_nxt;
         bank_r <= bank_nxt;
         acc_out <= acc_nxt;
         flags_out <= flags_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // Data memory, flip-flops written by index
   // ----------------------------------------------------------------------
   // Cleared at reset so operands are never unknown
   integer k;
   always @(posedge mclk_in)
   begin
      if (sys_rst_in)
      begin
         for (k = 0; k < DEPTH; k = k + 1)
            mem_r[k] <= `BAL_RST_BYTE;
      end
      else if (mem_we_nxt)
         mem_r[mem_wa_nxt] <= mem_wd_nxt;
   end

endmodule // bal_core

/* File: verification/bal_core_chk.sv */
/*
 Port checks for the byte ALU core, bound into bal_core.
 Assumes one slave on AHB-Lite and one clock with synchronous reset.
*/
`timescale 1ns/1ps
`include "bal_defs.vh"

module bal_core_chk #(
   parameter MEM_AW = 8
)(
   // Clock and reset
   input wire mclk_in,
   input wire sys_rst_in,
   // Bus
   input wire hsel_in,
   input wire [31:0] haddr_in,
   input wire [1:0] htrans_in,
   input wire hwrite_in,
   input wire [2:0] hsize_in,
   input wire [31:0] hwdata_in,
   input wire hready_in,
   input wire [31:0] hrdata_out,
   input wire hreadyout_out,
   input wire hresp_out,
   // Datapath
   input wire [7:0] acc_out,
   input wire [4:0] flags_out
);
   // ----------------------------------------
   // Data phase tracking
   // ----------------------------------------
   reg wr_dp_r;
   reg [7:0] wr_ofs_r;
   wire wr_take = hsel_in & htrans_in[1] & hready_in & hwrite_in;
   wire rd_take = hsel_in & htrans_in[1] & hready_in & ~hwrite_in;
   wire [3:0] op = hwdata_in[3:0];
   wire cmd_wr = wr_dp_r & (wr_ofs_r == `BAL_OFS_CMD);
   wire op_lacc = cmd_wr & (op inside {4'h1, 4'h3, 4'h8});
   wire op_logic = op_lacc | (cmd_wr & (op inside {4'h2, 4'h9}));
   wire op_add = cmd_wr & (op inside {4'h4, 4'h6});

   // Data phase follows the address phase by one edge; the command takes effect at the next edge
   always @(posedge mclk_in)
   begin
      if (sys_rst_in)
      begin
         wr_dp_r <= 1'b0;
         wr_ofs_r <= 8'h00;
      end
      else
      begin
         wr_dp_r <= wr_take;
         wr_ofs_r <= {haddr_in[7:2], 2'b00};
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (sys_rst_in);

   chk_resp_okay: assert property (hresp_out == 1'b0)
      else $error("response not okay");
   chk_read_wait: assert property (rd_take |=> !hreadyout_out ##1 hreadyout_out)
      else $error("read wait state wrong");
   chk_write_nowait: assert property (wr_take |=> hreadyout_out)
      else $error("write stalled");
   chk_reset_clear: assert property ($fell(sys_rst_in) |-> acc_out == 8'h00 && flags_out == 5'h00)
      else $error("state not cleared by reset");
   chk_acc_quiet: assert property (!wr_dp_r |=> $stable(acc_out))
      else $error("accumulator moved without write");
   chk_flag_quiet: assert property (!wr_dp_r |=> $stable(flags_out))
      else $error("flags moved without write");
   chk_clear_keep: assert property (cmd_wr && op inside {4'hA, 4'hB} |=>
      $stable(flags_out) && $stable(acc_out)) else $error("clear touched flags");
   chk_logic_zero: assert property (op_lacc |=> flags_out[2] == (acc_out == 8'h00))
      else $error("zero flag wrong after logic op");
   chk_logic_keep: assert property (op_logic |=>
      $stable(flags_out[1:0]) && $stable(flags_out[4:3])) else $error("logic op moved flags");
   chk_add_sign: assert property (op_add |=> flags_out[4] == (flags_out[3] ^ acc_out[7]) &&
      flags_out[2] == (acc_out == 8'h00)) else $error("add flags inconsistent");
   chk_mem_acc: assert property (cmd_wr && op inside {4'h2, 4'h5, 4'h7, 4'h9} |=>
      $stable(acc_out)) else $error("memory op changed accumulator");

   cov_read: cover property (rd_take ##1 !hreadyout_out ##1 hreadyout_out);
   cov_add: cover property (op_add);
   cov_clear_bit: cover property (cmd_wr && op == `BAL_OP_CLR_BIT);
endmodule // bal_core_chk

bind bal_core bal_core_chk #(.MEM_AW(MEM_AW)) u_bal_core_chk (.mclk_in(mclk_in),
   .sys_rst_in(sys_rst_in), .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in),
   .hwrite_in(hwrite_in), .hsize_in(hsize_in), .hwdata_in(hwdata_in), .hready_in(hready_in),
   .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
   .acc_out(acc_out), .flags_out(flags_out));

/* File: verification/tb_byte_alu_logic_add_clear.sv */
/*
 Self-checking bench for bal_core: command table, then bank addressing,
 unmapped offset and mid-run reset. Assumes hready loops back (one slave).
*/
`timescale 1ns/1ps
`include "bal_defs.vh"

module tb_byte_alu_logic_add_clear;
   // ----------------------------------------
   // Signals and design
   // ----------------------------------------
   logic mclk_in = 0, sys_rst_in = 1, hsel_in = 0, hwrite_in = 0;
   logic [31:0] haddr_in = 32'h0, hwdata_in = 32'h0, hrdata_out, rd;
   logic [1:0] htrans_in = 2'h0;
   logic [2:0] hsize_in = 3'h2;
   logic hreadyout_out, hresp_out;
   logic [7:0] acc_out;
   logic [4:0] flags_out;
   int n_mismatch = 0, n_tests = 0;
   typedef struct {logic [7:0] cmd, acc, mem, imm, eacc, emem; logic [4:0] st, efl;} bal_row_t;
   // cmd, acc, mem, imm, expected acc, expected mem, flags in, expected flags
   bal_row_t rows [11] = '{
      '{8'h01, 8'h5A, 8'h5A, 8'h00, 8'h00, 8'h5A, 5'h1B, 5'h1F},
      '{8'h02, 8'hF0, 8'h0F, 8'h00, 8'hF0, 8'hFF, 5'h04, 5'h00},
      '{8'h03, 8'h3C, 8'h11, 8'h3C, 8'h00, 8'h11, 5'h13, 5'h17},
      '{8'h04, 8'h7F, 8'h00, 8'h00, 8'h80, 8'h00, 5'h01, 5'h0A},
      '{8'h05, 8'hFF, 8'h00, 8'h00, 8'hFF, 8'h00, 5'h01, 5'h07},
      '{8'h06, 8'h80, 8'h80, 8'h00, 8'h00, 8'h80, 5'h01, 5'h1D},
      '{8'h07, 8'h12, 8'h34, 8'h00, 8'h12, 8'h46, 5'h1F, 5'h00},
      '{8'h08, 8'hF0, 8'h0F, 8'h00, 8'h00, 8'h0F, 5'h1B, 5'h1F},
      '{8'h09, 8'h3C, 8'hF5, 8'h00, 8'h3C, 8'h34, 5'h04, 5'h00},
      '{8'h0A, 8'hAA, 8'hFF, 8'h00, 8'hAA, 8'h00, 5'h0B, 5'h0B},
      '{8'h5B, 8'hAA, 8'hFF, 8'h00, 8'hAA, 8'hDF, 5'h04, 5'h04}};

   bal_core u_bal_core (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .hsel_in(hsel_in),
      .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in),
      .hwdata_in(hwdata_in), .hready_in(hreadyout_out), .hrdata_out(hrdata_out),
      .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .acc_out(acc_out),
      .flags_out(flags_out));

   // 10 MHz clock
   initial
   begin
      forever #50 mclk_in = ~mclk_in;
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   // Single word transfer; each phase held until hready is sampled high
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge mclk_in);
      hsel_in <= 1'b1;
      htrans_in <= 2'h2;
      haddr_in <= {24'h0, a};
      hwrite_in <= w;
      @(posedge mclk_in);
      while (hreadyout_out !== 1'b1) @(posedge mclk_in);
      hsel_in <= 1'b0;
      htrans_in <= 2'h0;
      hwdata_in <= wd;
      @(posedge mclk_in);
      while (hreadyout_out !== 1'b1) @(posedge mclk_in);
      rd = hrdata_out;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial
   begin
      repeat (8) @(posedge mclk_in);
      sys_rst_in <= 1'b0;
      foreach (rows[i])
      begin
         bus(1, `BAL_OFS_STATUS, 32'(rows[i].st));
         bus(1, `BAL_OFS_ACC, 32'(rows[i].acc));
         bus(1, `BAL_OFS_ADDR, 32'h40);
         bus(1, `BAL_OFS_MDATA, 32'(rows[i].mem));
         bus(1, `BAL_OFS_IMM, 32'(rows[i].imm));
         bus(1, `BAL_OFS_CMD, 32'(rows[i].cmd));
         @(negedge mclk_in);
         check(32'(acc_out), 32'(rows[i].eacc));
         check(32'(flags_out), 32'(rows[i].efl));
         bus(0, `BAL_OFS_MDATA, 32'h0);
         check(rd, 32'(rows[i].emem));
      end
      // Extended form must ignore bank select, ordinary form must not
      bus(1, `BAL_OFS_ADDR, 32'h85);
      bus(1, `BAL_OFS_MDATA, 32'h0F);
      bus(1, `BAL_OFS_ADDR, 32'h05);
      bus(1, `BAL_OFS_MDATA, 32'hF0);
      bus(1, `BAL_OFS_BANK, 32'h1);
      bus(1, `BAL_OFS_ACC, 32'hFF);
      bus(1, `BAL_OFS_CMD, 32'h08);
      @(negedge mclk_in);
      check(32'(acc_out), 32'hF0);
      bus(1, `BAL_OFS_CMD, 32'h01);
      @(negedge mclk_in);
      check(32'(acc_out), 32'hFF);
      // Unmapped offset reads zero, write dropped
      bus(1, 8'h1C, 32'hFFFF_FFFF);
      bus(0, 8'h1C, 32'h0);
      check(rd, 32'h0);
      // Spare command code does nothing but is recorded in CMD
      bus(1, `BAL_OFS_CMD, 32'h0C);
      @(negedge mclk_in);
      check(32'(acc_out), 32'hFF);
      check(32'(flags_out), 32'h00);
      bus(0, `BAL_OFS_CMD, 32'h0);
      check(rd, 32'h0C);
      // Second reset in mid-run clears state and memory
      @(posedge mclk_in);
      sys_rst_in <= 1'b1;
      repeat (2) @(posedge mclk_in);
      sys_rst_in <= 1'b0;
      @(negedge mclk_in);
      check(32'(acc_out), 32'h0);
      check(32'(flags_out), 32'h0);
      bus(1, `BAL_OFS_ADDR, 32'h85);
      bus(0, `BAL_OFS_MDATA, 32'h0);
      check(rd, 32'h0);
      finish_test();
   end

   // Watchdog, far beyond the few hundred cycles the sequence needs
   initial
   begin
      #3_000_000;
      n_mismatch++;
      finish_test();
   end
endmodule // tb_byte_alu_logic_add_clear
